/* hdl/cdc_sync.sv */
// Two-stage level synchroniser.
`timescale 1ns/1ns
module cdc_sync
#(
   parameter int unsigned W = 1
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   always_comb
   begin
      s_d    = s_q;
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign q = s_q.s2;

endmodule

/* hdl/sai_pkg.sv */
// Shared constants of the serial audio input port.
package sai_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [11:0] CTRL_IDX = 12'h81F;
   localparam logic [11:0] STAT_IDX = 12'h820;
   localparam logic [11:0] CH0_IDX  = 12'h821;

   // Control register fields.
   localparam int unsigned FMT_LSB  = 0;
   localparam int unsigned BCP_BIT  = 3;
   localparam int unsigned FCP_BIT  = 4;
   localparam int unsigned CTRL_W   = 5;
   localparam logic [4:0]  CTRL_RST = 5'h00;

   // Status register fields.
   localparam int unsigned RDY_BIT  = 0;
   localparam int unsigned FCNT_LSB = 8;

   // Receive format codes.
   localparam logic [2:0] FMT_I2S  = 3'h0;
   localparam logic [2:0] FMT_LJ   = 3'h1;
   localparam logic [2:0] FMT_TDM  = 3'h2;
   localparam logic [2:0] FMT_RJ24 = 3'h3;
   localparam logic [2:0] FMT_RJ20 = 3'h4;

   // Frame geometry.
   localparam int unsigned NUM_IN    = 4;
   localparam int unsigned NUM_CH    = 8;
   localparam int unsigned WORD_W    = 24;
   localparam int unsigned SHORT_W   = 20;
   localparam int unsigned SLOT_BITS = 32;
   localparam int unsigned SLOT_LG   = 5;

   // Bit position of the MSB counted from the start of a slot.
   function automatic logic [8:0] msb_delay(input logic [2:0] fmt);
      case (fmt)
         FMT_LJ:   msb_delay = 9'h000;
         FMT_RJ24: msb_delay = 9'(SLOT_BITS - WORD_W);
         FMT_RJ20: msb_delay = 9'(SLOT_BITS - SHORT_W);
         default:  msb_delay = 9'h001;
      endcase
   endfunction

   // Number of data bits carried in one slot.
   function automatic logic [8:0] word_len(input logic [2:0] fmt);
      word_len = (fmt == FMT_RJ20) ? 9'(SHORT_W) : 9'(WORD_W);
   endfunction

endpackage

/* hdl/sai_rx_core.sv */
// Link-side deserialiser of the serial audio input port.
`timescale 1ns/1ns
module sai_rx_core
#(
   parameter int unsigned NIN = sai_pkg::NUM_IN,
   parameter int unsigned NCH = sai_pkg::NUM_CH,
   parameter int unsigned WW  = sai_pkg::WORD_W
)
(
   input  wire logic              sample_clk,
   input  wire logic              rst_n,
   input  wire logic [4:0]        ctrl,
   input  wire logic              frame_clk,
   input  wire logic [NIN-1:0]    sdata,
   output logic      [NCH*WW-1:0] frame_words,
   output logic                   frame_tog
);

   typedef struct packed {
      logic              live;
      logic              lr;
      logic [8:0]        cnt;
      logic              seen;
      logic              tog;
      logic [NIN*WW-1:0] sh;
      logic [NCH*WW-1:0] work;
      logic [NCH*WW-1:0] hold;
   } rx_t;

   rx_t        s_q;
   rx_t        s_d;
   logic [2:0] fmt;
   logic       left_lvl;
   logic       fstart;
   logic       tdm;
   logic [8:0] pos;
   logic [8:0] ipos;
   logic [8:0] dly;
   logic [8:0] wl;
   logic       last;
   logic [3:0] slot;
   logic [WW-1:0] word;
   int         chn;

   always_comb
   begin
      s_d  = s_q;
      word = '0;
      chn  = 0;
      fmt  = ctrl[sai_pkg::FMT_LSB +: 3];
      tdm  = fmt == sai_pkg::FMT_TDM;
      left_lvl = frame_clk == ctrl[sai_pkg::FCP_BIT];  // see [RULE1]
      // A square clock and a pulse both start a frame on their first edge
      // into the left level. The first sample after reset only primes the
      // edge detector, since the idle level of the pin is unknown.
      fstart = s_q.live && (frame_clk != s_q.lr) && left_lvl;  // see [RULE2] [RULE3] [RULE4]
      pos  = (tdm ? fstart : (frame_clk != s_q.lr)) ? 9'h000 : s_q.cnt;
      ipos = tdm ? {4'h0, pos[sai_pkg::SLOT_LG-1:0]} : pos;
      slot = tdm ? pos[8:sai_pkg::SLOT_LG] : {3'h0, !left_lvl};  // see [RULE12]
      dly  = sai_pkg::msb_delay(fmt);  // see [RULE11] [RULE7]
      wl   = sai_pkg::word_len(fmt);
      last = (fmt <= sai_pkg::FMT_RJ20) && (ipos == dly + wl - 9'h001);  // see [RULE14]
      s_d.live = 1'b1;
      s_d.lr  = frame_clk;
      s_d.cnt = (pos == 9'h1FF) ? pos : pos + 9'h001;
      for (int i = 0; i < NIN; i++)
      begin
         s_d.sh[i*WW +: WW] = {s_q.sh[i*WW +: WW-1], sdata[i]};
         if (last && (!tdm || (i == 0 && int'(slot) < NCH)))
         begin
            word = WW'(s_d.sh[i*WW +: WW] << (9'(WW) - wl));
            chn  = tdm ? int'(slot) : 2 * i + int'(slot);  // see [RULE10]
            s_d.work[chn*WW +: WW] = word;
         end
      end
      if (fstart)
      begin
         s_d.seen = 1'b1;
         if (s_q.seen)
         begin
            s_d.hold = s_q.work;
            s_d.tog  = !s_q.tog;
         end
      end
   end

   always_ff @(posedge sample_clk or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign frame_words = s_q.hold;
   assign frame_tog   = s_q.tog;

   ////////////////////////////////////////////////////////////////////////

   tdm_fall_a: assert property (@(posedge sample_clk) disable iff (!rst_n)
      tdm && !ctrl[4] && $fell(frame_clk) |=> s_q.cnt == 9'h001)  // see [RULE2]
      else $error("TDM frame did not start after falling frame clock");

   tdm_rise_a: assert property (@(posedge sample_clk) disable iff (!rst_n)
      tdm && ctrl[4] && $rose(frame_clk) |=> s_q.cnt == 9'h001)  // see [RULE3]
      else $error("TDM frame did not start after rising frame clock");

   frame_hold_a: assert property (@(posedge sample_clk) disable iff (!rst_n)
      fstart && s_q.seen |=> frame_tog != $past(frame_tog))  // see [RULE4]
      else $error("Frame start did not publish the frame");

   i2s_left_a: assert property (@(posedge sample_clk) disable iff (!rst_n)
      fmt == sai_pkg::FMT_I2S && left_lvl && pos == 9'd24
      |=> s_q.work[WW-1:0] == $past(s_d.sh[WW-1:0]))  // see [RULE1] [RULE11]
      else $error("Left word not stored in channel 0");

   tdm_ch4_a: assert property (@(posedge sample_clk) disable iff (!rst_n)
      tdm && pos == 9'd152
      |=> s_q.work[4*WW +: WW] == $past(s_d.sh[WW-1:0]))  // see [RULE12]
      else $error("TDM slot 4 not stored in channel 4");

   rsvd_fmt_a: assert property (@(posedge sample_clk) disable iff (!rst_n)
      fmt > sai_pkg::FMT_RJ20 |=> $stable(s_q.work))  // see [RULE14]
      else $error("Reserved format changed channel data");

   tdm_frame_c: cover property (@(posedge sample_clk) disable iff (!rst_n)
      tdm && fstart && s_q.seen);

   i2s_frame_c: cover property (@(posedge sample_clk) disable iff (!rst_n)
      fmt == sai_pkg::FMT_I2S && fstart && s_q.seen);

endmodule

/* hdl/serial_audio_input_port.sv */
// Serial audio input port: AHB-Lite registers and link clocking.
`timescale 1ns/1ns
// Functional notes
// [RULE1] Polarity 0: left while frame clock low, right while high; 1 swaps.
// [RULE2] Multiplexed, polarity 0: frame starts on sample edge after a fall.
// [RULE3] Multiplexed, polarity 1: data valid from sample edge after a rise.
// [RULE4] A frame-clock pulse is accepted; its first edge starts the frame.
// [RULE5] Source sends low pulse for polarity 0, high pulse for polarity 1.
// [RULE6] Bit polarity 0: data changes falling, sampled rising; 1 reverses.
// [RULE7] Both polarity bits together with the format code set timing.
// [RULE8] Software writes both polarity bits and format bits together.
// [RULE9] Justified formats need frame polarity set opposite to default.
// [RULE10] Multiplexed stream arrives on serial data input zero only.
// [RULE11] Multiplexed slots carry the MSB one bit clock after slot start.
// [RULE12] Multiplexed channels 0-3 in first half, 4-7 in second half.
// [RULE13] Pulse clock use: rising start, falling data, MSB delayed one.
// [RULE14] Format field picks I2S, left, multiplexed, right; rest reserved.
module serial_audio_input_port
#(
   parameter int unsigned NIN = sai_pkg::NUM_IN,
   parameter int unsigned NCH = sai_pkg::NUM_CH,
   parameter int unsigned WW  = sai_pkg::WORD_W
)
(
   input  wire logic           hclk,
   input  wire logic           hresetn,
   input  wire logic           hsel,
   input  wire logic [31:0]    haddr,
   input  wire logic [1:0]     htrans,
   input  wire logic           hwrite,
   input  wire logic [2:0]     hsize,
   input  wire logic [31:0]    hwdata,
   input  wire logic           hready,
   output logic                hreadyout,
   output logic                hresp,
   output logic      [31:0]    hrdata,
   input  wire logic           bit_clk,
   input  wire logic           frame_clk,
   input  wire logic [NIN-1:0] serial_data_inputs
);

   typedef struct packed {
      logic [4:0]        ctrl;
      logic              ready;
      logic [7:0]        fcnt;
      logic              tog;
      logic [NCH*WW-1:0] words;
      logic              wpend;
      logic [11:0]       widx;
      logic [31:0]       rdata;
   } regs_t;

   regs_t             s_q;
   regs_t             s_d;
   logic              aphase;
   logic              amap;
   logic [11:0]       aidx;
   logic [11:0]       chn;
   logic              fedge;
   logic              tog_sync;
   logic              frame_tog;
   logic [NCH*WW-1:0] frame_words;
   logic [4:0]        ctrl_link;
   logic              sample_clk;

   ////////////////////////////////////////////////////////////////////////
   // Register file on the system clock.

   always_comb
   begin
      s_d    = s_q;
      chn    = 12'h000;
      aphase = hsel && htrans[1] && hready;
      amap   = ~|haddr[31:14] && haddr[1:0] == 2'h0;
      aidx   = haddr[13:2];
      fedge  = tog_sync != s_q.tog;
      s_d.tog   = tog_sync;
      s_d.wpend = aphase && hwrite && amap;
      s_d.widx  = aidx;
      if (aphase && !hwrite)
      begin
         s_d.rdata = 32'h0000_0000;
         chn = aidx - sai_pkg::CH0_IDX;
         if (amap && aidx == sai_pkg::CTRL_IDX)
            s_d.rdata[sai_pkg::CTRL_W-1:0] = s_q.ctrl;
         else if (amap && aidx == sai_pkg::STAT_IDX)
         begin
            s_d.rdata[sai_pkg::RDY_BIT] = s_q.ready;
            s_d.rdata[sai_pkg::FCNT_LSB +: 8] = s_q.fcnt;
         end
         else if (amap && chn < 12'(NCH))
            s_d.rdata[WW-1:0] = s_q.words[int'(chn)*WW +: WW];
      end
      if (s_q.wpend)
      begin
         // All five control bits land in one write, so polarity and
         // format never disagree between two bus cycles.
         if (s_q.widx == sai_pkg::CTRL_IDX)
            s_d.ctrl = hwdata[sai_pkg::CTRL_W-1:0];  // see [RULE7] [RULE8]
         if (s_q.widx == sai_pkg::STAT_IDX && hwdata[sai_pkg::RDY_BIT])
            s_d.ready = 1'b0;
      end
      // A new frame beats a clear in the same cycle.
      if (fedge)
      begin
         s_d.ready = 1'b1;  // see [RULE4]
         s_d.fcnt  = s_q.fcnt + 8'h01;
         s_d.words = frame_words;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q      <= '0;
         s_q.ctrl <= sai_pkg::CTRL_RST;
      end
      else
         s_q <= s_d;
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////
   // Link clocking.

   // Control is quasi-static: software must only change it while the link
   // is idle, since the sampling clock itself depends on it.
   cdc_sync #(.W(sai_pkg::CTRL_W)) u_ctrl_sync
   (
      .clk   (bit_clk),
      .rst_n (hresetn),
      .d     (s_q.ctrl),
      .q     (ctrl_link)
   );

   // Sampling on the edge opposite to the launch edge: inverting the bit
   // clock keeps one clock domain at the cost of a glitch when the
   // polarity bit changes.
   assign sample_clk = bit_clk ^ ctrl_link[sai_pkg::BCP_BIT];  // see [RULE6]

   sai_rx_core #(.NIN(NIN), .NCH(NCH), .WW(WW)) u_rx
   (
      .sample_clk  (sample_clk),
      .rst_n       (hresetn),
      .ctrl        (ctrl_link),
      .frame_clk   (frame_clk),
      .sdata       (serial_data_inputs),
      .frame_words (frame_words),
      .frame_tog   (frame_tog)
   );

   // The published bank stays still for a whole frame, far longer than
   // the toggle needs to cross, so it is copied without its own sync.
   cdc_sync #(.W(1)) u_tog_sync
   (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     (frame_tog),
      .q     (tog_sync)
   );

   ////////////////////////////////////////////////////////////////////////

   ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.wpend && s_q.widx == sai_pkg::CTRL_IDX
      |=> s_q.ctrl == $past(hwdata[4:0]))  // see [RULE7]
      else $error("Control write not stored");

   ready_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fedge |=> s_q.ready && s_q.fcnt == $past(s_q.fcnt) + 8'h01)  // see [RULE4]
      else $error("Frame arrival not recorded");

   bank_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fedge |=> s_q.words == $past(frame_words))  // see [RULE12]
      else $error("Frame words not copied");

   ctrl_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      aphase && !hwrite && amap && aidx == sai_pkg::CTRL_IDX
      |=> hrdata == {27'h0, $past(s_q.ctrl)})  // see [RULE7]
      else $error("Control read back wrong");

   always_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("Slave left OKAY zero-wait answer");

   status_clr_c: cover property (@(posedge hclk) disable iff (!hresetn)
      s_q.ready ##1 !s_q.ready);

   frame_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
      fedge ##[1:400] fedge);

endmodule

/* sim/audio_source_model.sv */
// Behavioural serial audio source feeding the input port.
`timescale 1ns/1ns
module audio_source_model
(
   output logic       bit_clk,
   output logic       frame_clk,
   output logic [3:0] sdata
);
   logic [23:0] words [8];

   initial
   begin
      bit_clk   = 1'h1;
      frame_clk = 1'h1;
      sdata     = 4'hA;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outside the word the line is not driven, so a toggling pattern is sent
   // rather than a held value that could pass for data by luck.
   function automatic logic slot_bit(input logic [2:0] fmt,
                                     input logic [23:0] w,
                                     input int p);
      int m;
      int wl;
      m  = (fmt == sai_pkg::FMT_LJ)   ? 0 :
           (fmt == sai_pkg::FMT_RJ24) ? 8 :
           (fmt == sai_pkg::FMT_RJ20) ? 12 : 1;
      wl = (fmt == sai_pkg::FMT_RJ20) ? 20 : 24;
      slot_bit = (p >= m && p < m + wl) ? w[23 - (p - m)] : p[0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sends nfr frames plus one more frame start, so that the last frame is
   // published. Four lead-in bits let the new settings settle at the link.
   task automatic send(input logic [2:0] fmt,
                       input logic       bcp,
                       input logic       fcp,
                       input logic       pulse,
                       input int         nfr);
      int   bits;
      int   n;
      int   i;
      int   k;
      logic tdm;
      tdm  = (fmt == sai_pkg::FMT_TDM);
      bits = tdm ? 256 : 64;
      #7;
      bit_clk   = ~bcp;
      frame_clk = ~fcp;
      for (i = -4; i < nfr * bits + 1; i++)
      begin
         n       = (i < 0) ? 1 : i % bits;
         bit_clk = bcp;
         if (i < 0)
            frame_clk = ~fcp;
         else if (tdm)
            frame_clk = (pulse ? n == 0 : n < 128) ? fcp : ~fcp;
         else
            frame_clk = (n < 32) ? fcp : ~fcp;
         for (k = 0; k < 4; k++)
            sdata[k] = tdm ? (k == 0 ? slot_bit(fmt, words[n / 32], n % 32)
                                     : ~n[0])
                           : slot_bit(fmt, words[2 * k + n / 32], n % 32);
         #62 bit_clk = ~bcp;
         #63;
      end
      sdata = ~sdata;
   endtask
endmodule

/* sim/tb.sv */
// Self-checking testbench of the serial audio input port.
`timescale 1ns/1ns
module tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        bit_clk;
   logic        frame_clk;
   logic [3:0]  sdata;
   logic [23:0] last [8];
   int          num_errors;
   int          comparisons;
   // Each entry is pulse, frame polarity, bit polarity, format.
   // Entry 3 is the pulse word clock setup for codec interfacing.
   logic [5:0]  cfg [8] = '{6'h00, 6'h19, 6'h02, 6'h32,
                            6'h13, 6'h1C, 6'h05, 6'h0A};

   serial_audio_input_port u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .bit_clk(bit_clk), .frame_clk(frame_clk),
      .serial_data_inputs(sdata));

   audio_source_model u_src (.bit_clk(bit_clk), .frame_clk(frame_clk),
      .sdata(sdata));

   initial hclk = 1'h0;
   always #20 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      ahb(1'h0, {18'h0, idx, 2'h0}, 32'h0, d);
      chk(d, exp);
   endtask

   task automatic wr(input logic [11:0] idx, input logic [31:0] v);
      logic [31:0] d;
      ahb(1'h1, {18'h0, idx, 2'h0}, v, d);
   endtask

   function automatic logic [23:0] wd(input int s, input int c);
      wd = {4'hA ^ 4'(s), 4'(c), 12'h5C3, 4'(s + c + 1)};
   endfunction

   task automatic end_sim;
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Eight scenarios of two TDM frames at most stay far below this span.
   initial
   begin
      #1000000;
      num_errors++;
      end_sim;
   end

   initial
   begin
      int          s;
      int          c;
      logic [23:0] w;
      num_errors  = 0;
      comparisons = 0;
      hresetn     = 1'h0;
      hsel        = 1'h0;
      haddr       = 32'h0;
      htrans      = 2'h0;
      hwrite      = 1'h0;
      hsize       = 3'h2;
      hwdata      = 32'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      rc(sai_pkg::CTRL_IDX, 32'h0);
      rc(12'hC00, 32'h0);
      for (s = 0; s < 8; s++)
      begin
         for (c = 0; c < 8; c++)
            u_src.words[c] = wd(s, c);
         wr(sai_pkg::CTRL_IDX, {27'h0, cfg[s][4:0]});
         rc(sai_pkg::CTRL_IDX, {27'h0, cfg[s][4:0]});
         u_src.send(cfg[s][2:0], cfg[s][3], cfg[s][4], cfg[s][5], 2);
         repeat (20) @(posedge hclk);
         for (c = 0; c < 8; c++)
         begin
            w = wd(s, c);
            if (cfg[s][2:0] == sai_pkg::FMT_RJ20)
               w[3:0] = 4'h0;
            // A reserved format captures nothing, so the old words stay.
            if (cfg[s][2:0] > sai_pkg::FMT_RJ20)
               w = last[c];
            last[c] = w;
            rc(sai_pkg::CH0_IDX + 12'(c), {8'h00, w});
         end
         if (s == 0)
         begin
            rc(sai_pkg::STAT_IDX, 32'h0000_0201);
            wr(sai_pkg::STAT_IDX, 32'h1);
            rc(sai_pkg::STAT_IDX, 32'h0000_0200);
         end
      end
      wr(sai_pkg::CTRL_IDX, 32'hFFFF_FFFF);
      rc(sai_pkg::CTRL_IDX, 32'h0000_001F);
      end_sim;
   end
endmodule
